// File: bfam_top.sv
// Beam stability filter, beam evaluation and analog output mapping.
// Assumes beam states arrive on mclk with a one-cycle strobe per measurement
// cycle, an Avalon-MM master and a front panel on the same clock, and an
// external non-volatile store that answers one load request after reset.
`timescale 1ns/100ps
`default_nettype none
module bfam_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic panelWrite,
   input wire logic [4:0] panelAddr,
   input wire logic [31:0] panelWriteData,
   input wire logic [31:0] beamBlocked,
   input wire logic beamStrobe,
   output logic nvLoadReq,
   input wire logic nvLoadValid,
   input wire bfam_pkg::bfam_cfg_type nvLoadImage,
   output logic nvSave,
   output bfam_pkg::bfam_cfg_type nvImage,
   output bfam_pkg::bfam_dac_type analogOut
);

   localparam int BC = bfam_pkg::BEAM_COUNT;

   typedef enum logic {PH_BOOT, PH_RUN} bfam_phase_type;

   typedef struct packed {
      bfam_phase_type phase;
      logic ack;
      logic waitReq;
      logic [31:0] rdata;
      bfam_pkg::bfam_cfg_type cfg;
      logic nvReq;
      logic nvSave;
      logic loaded;
      logic reject;
      logic [BC-1:0] prevBeams;
      logic [7:0] stableCnt;
      logic stable;
      logic evalPend;
      logic [BC-1:0] heldBeams;
      logic [7:0] value;
      logic invert;
      logic evalOff;
      logic divBusy;
      bfam_pkg::bfam_dac_type analog;
   } bfam_top_state_type;

   localparam bfam_top_state_type RESET_STATE = '{
      phase: PH_BOOT, waitReq: 1'b1, cfg: bfam_pkg::CFG_DEFAULT, default: '0};

   bfam_top_state_type s;
   bfam_top_state_type next_s;

   // ----------------------------------------
   // Register access helpers
   // ----------------------------------------
   function automatic logic [31:0] regRead(input bfam_top_state_type st,
                                           input logic [4:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         bfam_pkg::REG_DEPTH: r[7:0] = st.cfg.depth;
         bfam_pkg::REG_SIGNAL: r[2:0] = st.cfg.sigType;
         bfam_pkg::REG_FUNC: r[2:0] = st.cfg.func;
         bfam_pkg::REG_START: r[7:0] = st.cfg.startBeam;
         bfam_pkg::REG_END: r[7:0] = st.cfg.endBeam;
         bfam_pkg::REG_SMOOTH: r[7:0] = st.cfg.smoothing;
         bfam_pkg::REG_STATUS: begin
            r[bfam_pkg::ST_REJECT_BIT] = st.reject;
            r[bfam_pkg::ST_INVERT_BIT] = st.invert;
            r[bfam_pkg::ST_STABLE_BIT] = st.stable;
            r[bfam_pkg::ST_LOADED_BIT] = st.loaded;
            r[bfam_pkg::ST_VALUE_LSB +: 8] = st.value;
            r[bfam_pkg::ST_CODE_LSB +: 12] = st.analog.code;
         end
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   function automatic logic beamOk(input logic [15:0] v);
      return (v >= 16'h0001) && (v <= bfam_pkg::BEAM_LAST16);
   endfunction

   // Any value whose low 16 bits lie outside its field's range is refused as a whole.
   function automatic logic badWrite(input logic [4:0] a, input logic [31:0] d);
      logic bad;
      bad = 1'b0;
      case (a)
         bfam_pkg::REG_DEPTH: bad = d[15:0] > bfam_pkg::DEPTH_MAX;
         bfam_pkg::REG_SIGNAL: bad = d[15:0] > 16'h0006;
         bfam_pkg::REG_FUNC: bad = d[15:0] > 16'h0006;
         bfam_pkg::REG_START: bad = !beamOk(d[15:0]);
         bfam_pkg::REG_END: bad = !beamOk(d[15:0]);
         bfam_pkg::REG_SMOOTH: bad = d[15:0] > bfam_pkg::BEAM_LAST16;
         default: bad = 1'b0;
      endcase
      return bad;
   endfunction

   function automatic bfam_pkg::bfam_cfg_type cfgWrite(
         input bfam_pkg::bfam_cfg_type c, input logic [4:0] a, input logic [31:0] d);
      bfam_pkg::bfam_cfg_type r;
      r = c;
      if (!badWrite(a, d)) begin
         case (a)
            bfam_pkg::REG_DEPTH: r.depth = d[7:0];
            bfam_pkg::REG_SIGNAL: r.sigType = d[2:0];
            bfam_pkg::REG_FUNC: r.func = d[2:0];
            bfam_pkg::REG_START: r.startBeam = d[7:0];
            bfam_pkg::REG_END: r.endBeam = d[7:0];
            bfam_pkg::REG_SMOOTH: r.smoothing = d[7:0];
            default: r = c;
         endcase
      end
      return r;
   endfunction

   function automatic logic cfgValid(input bfam_pkg::bfam_cfg_type c);
      return (c.sigType <= bfam_pkg::SIG_MA0_24) &&
             (c.func <= bfam_pkg::FN_TOTAL_CLEAR_BEAMS) &&
             beamOk({8'h00, c.startBeam}) && beamOk({8'h00, c.endBeam}) &&
             (c.smoothing <= bfam_pkg::BEAM_LAST8);
   endfunction

   // ----------------------------------------
   // Smoothing of short blocked runs
   // ----------------------------------------
   // A blocked beam counts only when its run of adjacent blocked beams is at
   // least the smoothing length; the run is the forward plus backward length, less one.
   logic [7:0] runFwd [BC];
   logic [7:0] runBwd [BC];
   logic [BC-1:0] effBlocked;

   genvar g;
   generate
      for (g = 0; g < BC; g++) begin : gRun
         if (g == 0) begin : gLow
            assign runFwd[g] = s.heldBeams[g] ? 8'h01 : 8'h00;
         end else begin : gUp
            assign runFwd[g] = s.heldBeams[g] ? 8'(runFwd[g-1] + 8'h01) : 8'h00;
         end
         if (g == BC - 1) begin : gTop
            assign runBwd[g] = s.heldBeams[g] ? 8'h01 : 8'h00;
         end else begin : gDn
            assign runBwd[g] = s.heldBeams[g] ? 8'(runBwd[g+1] + 8'h01) : 8'h00;
         end
         assign effBlocked[g] = s.heldBeams[g] &&
            (({1'b0, runFwd[g]} + {1'b0, runBwd[g]}) > {1'b0, s.cfg.smoothing});
      end
   endgenerate

   // ----------------------------------------
   // Evaluation functions and range position
   // ----------------------------------------
   logic [7:0] firstB, firstC, lastB, lastC, totB, evalVal;
   logic [7:0] lo, hi, span, pos;
   logic invertNow;

   always_comb begin
      firstB = 8'h00;
      firstC = 8'h00;
      lastB = 8'h00;
      lastC = 8'h00;
      totB = 8'h00;
      for (int i = BC - 1; i >= 0; i--) begin
         if (effBlocked[i]) begin
            firstB = 8'(i + 1);
         end else begin
            firstC = 8'(i + 1);
         end
      end
      for (int i = 0; i < BC; i++) begin
         if (effBlocked[i]) begin
            lastB = 8'(i + 1);
         end else begin
            lastC = 8'(i + 1);
         end
         totB = 8'(totB + {7'h00, effBlocked[i]});
      end
      case (s.cfg.func)
         bfam_pkg::FN_FIRST_BLOCKED_BEAM: evalVal = firstB;
         bfam_pkg::FN_FIRST_CLEAR_BEAM: evalVal = firstC;
         bfam_pkg::FN_LAST_BLOCKED_BEAM: evalVal = lastB;
         bfam_pkg::FN_LAST_CLEAR_BEAM: evalVal = lastC;
         bfam_pkg::FN_TOTAL_BLOCKED_BEAMS: evalVal = totB;
         bfam_pkg::FN_TOTAL_CLEAR_BEAMS: evalVal = 8'(bfam_pkg::BEAM_LAST8 - totB);
         default: evalVal = 8'h00;
      endcase
      invertNow = s.cfg.endBeam < s.cfg.startBeam;
      lo = invertNow ? s.cfg.endBeam : s.cfg.startBeam;
      hi = invertNow ? s.cfg.startBeam : s.cfg.endBeam;
      span = 8'(hi - lo + 8'h01);
      if (evalVal < lo) begin
         pos = 8'h00;
      end else if (evalVal > hi) begin
         pos = span;
      end else begin
         pos = 8'(evalVal - lo + 8'h01);
      end
   end

   // ----------------------------------------
   // Scaling onto converter codes
   // ----------------------------------------
   // The divider trades latency for area: one result 21 clocks after start, far
   // shorter than a measurement cycle, so a stable result is never lost.
   logic divStart;
   logic divDone;
   logic [19:0] divQuot;
   logic [11:0] codeNow;

   assign divStart = s.evalPend && !s.divBusy;

   bfam_divider uDiv (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(divStart),
      .dividend({pos, 12'h000}),
      .divisor(span),
      .done(divDone),
      .quotient(divQuot)
   );

   always_comb begin
      codeNow = (divQuot > bfam_pkg::DIV_LIMIT) ? bfam_pkg::DAC_MAX : divQuot[11:0];
      if (s.evalOff) begin
         codeNow = 12'h000;
      end else if (s.invert) begin
         codeNow = 12'(bfam_pkg::DAC_MAX - codeNow);
      end
   end

   // ----------------------------------------
   // Main state update
   // ----------------------------------------
   logic [31:0] beMask;
   logic [31:0] busData;
   logic srcAct [2];
   logic [4:0] srcAddr [2];
   logic [31:0] srcData [2];
   logic anyBad;
   logic anyClr;
   logic [7:0] cntNow;

   always_comb begin
      beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      busData = (regRead(s, avs_address) & ~beMask) | (avs_writedata & beMask);
      // Panel comes second so that it wins a same-cycle tie.
      srcAct[0] = s.ack && avs_write;
      srcAddr[0] = avs_address;
      srcData[0] = busData;
      srcAct[1] = panelWrite;
      srcAddr[1] = panelAddr;
      srcData[1] = panelWriteData;
      anyBad = 1'b0;
      anyClr = 1'b0;
      cntNow = 8'h00;
      next_s = s;
      next_s.ack = 1'b0;
      next_s.nvSave = 1'b0;
      next_s.evalPend = 1'b0;
      next_s.analog.enable = s.cfg.sigType != bfam_pkg::SIG_OFF;
      next_s.analog.range = s.cfg.sigType;
      if ((avs_read || avs_write) && !s.ack) begin
         next_s.ack = 1'b1;
         next_s.rdata = regRead(s, avs_address);
      end
      next_s.waitReq = !next_s.ack;
      case (s.phase)
         PH_BOOT: begin
            next_s.nvReq = 1'b1;
            if (nvLoadValid) begin
               next_s.nvReq = 1'b0;
               next_s.phase = PH_RUN;
               next_s.loaded = 1'b1;
               next_s.cfg = cfgValid(nvLoadImage) ? nvLoadImage
                                                  : bfam_pkg::CFG_DEFAULT;
            end
         end
         PH_RUN: begin
            for (int k = 0; k < 2; k++) begin
               if (srcAct[k]) begin
                  if (srcAddr[k] == bfam_pkg::REG_CTRL &&
                      srcData[k][bfam_pkg::CTRL_FACTORY_BIT]) begin
                     next_s.cfg = bfam_pkg::CFG_DEFAULT;
                  end
                  if (srcAddr[k] == bfam_pkg::REG_STATUS &&
                      srcData[k][bfam_pkg::ST_REJECT_BIT]) begin
                     anyClr = 1'b1;
                  end
                  next_s.cfg = cfgWrite(next_s.cfg, srcAddr[k], srcData[k]);
                  anyBad = anyBad | badWrite(srcAddr[k], srcData[k]);
               end
            end
            next_s.reject = anyBad | (s.reject & ~anyClr);
            next_s.nvSave = next_s.cfg != s.cfg;
            if (beamStrobe) begin
               if (beamBlocked != s.prevBeams) begin
                  cntNow = 8'h01;
               end else begin
                  cntNow = (s.stableCnt == 8'hff) ? 8'hff : 8'(s.stableCnt + 8'h01);
               end
               next_s.prevBeams = beamBlocked;
               next_s.stableCnt = cntNow;
               next_s.stable = cntNow >= s.cfg.depth;
               if (cntNow >= s.cfg.depth) begin
                  next_s.heldBeams = beamBlocked;
                  next_s.evalPend = 1'b1;
               end
            end
         end
         default: next_s.phase = PH_BOOT;
      endcase
      if (divStart) begin
         next_s.divBusy = 1'b1;
         next_s.invert = invertNow;
         next_s.evalOff = s.cfg.func == bfam_pkg::FN_OFF;
         next_s.value = evalVal;
      end
      if (divDone) begin
         next_s.divBusy = 1'b0;
         next_s.analog.code = codeNow;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.waitReq;
   assign nvLoadReq = s.nvReq;
   assign nvSave = s.nvSave;
   assign nvImage = s.cfg;
   assign analogOut = s.analog;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_filter_gate: assert property (
      s.evalPend |-> s.stableCnt >= $past(s.cfg.depth))
      else $error("evaluation started before the beams were stable");

   a_count_restart: assert property (
      (s.phase == PH_RUN && beamStrobe && beamBlocked != s.prevBeams)
      |=> s.stableCnt == 8'h01 && !s.evalPend || s.cfg.depth <= 8'h01)
      else $error("stability count not restarted on a beam change");

   a_depth_refuse: assert property (
      (s.phase == PH_RUN && s.ack && avs_write && !panelWrite &&
       avs_address == bfam_pkg::REG_DEPTH && avs_byteenable == 4'hf &&
       avs_writedata[15:0] > 16'h00ff)
      |=> s.cfg.depth == $past(s.cfg.depth) && s.reject)
      else $error("out of range filter depth was accepted");

   a_range_follow: assert property (
      s.cfg.sigType == bfam_pkg::SIG_OFF [*2] |-> !analogOut.enable)
      else $error("analog output enabled while switched off");

   a_func_off: assert property (
      (divStart && s.cfg.func == bfam_pkg::FN_OFF) ##[1:25] divDone
      |=> analogOut.code == 12'h000)
      else $error("output not zero with evaluation off");

   a_curve_invert: assert property (
      (divDone && s.invert && !s.evalOff && divQuot == 20'h0_0000)
      |=> analogOut.code == 12'hfff)
      else $error("inverted curve did not reach full scale");

   a_code_scale: assert property (
      (divDone && !s.invert && !s.evalOff && divQuot <= 20'h0_0fff)
      |=> analogOut.code == $past(divQuot[11:0]))
      else $error("converter code does not match the scaled position");

   a_div_latency: assert property (
      divStart |-> ##21 divDone)
      else $error("scaling did not finish in 21 clocks");

   a_save_change: assert property (
      ($past(s.phase) == PH_RUN && s.cfg != $past(s.cfg)) |-> s.nvSave)
      else $error("configuration change not saved");

   a_boot_load: assert property (
      (s.phase == PH_BOOT && nvLoadValid && cfgValid(nvLoadImage))
      |=> s.cfg == $past(nvLoadImage) && s.phase == PH_RUN)
      else $error("stored configuration not applied at start");

   a_panel_wins: assert property (
      (s.phase == PH_RUN && s.ack && avs_write && panelWrite &&
       avs_address == bfam_pkg::REG_START && panelAddr == bfam_pkg::REG_START &&
       beamOk(panelWriteData[15:0]))
      |=> s.cfg.startBeam == $past(panelWriteData[7:0]))
      else $error("later write did not win");

   a_factory: assert property (
      (s.phase == PH_RUN && s.ack && avs_write && !panelWrite &&
       avs_address == bfam_pkg::REG_CTRL && avs_byteenable[0] && avs_writedata[0])
      |=> s.cfg == bfam_pkg::CFG_DEFAULT)
      else $error("factory command did not restore defaults");

   a_smooth_none: assert property (
      s.cfg.smoothing == 8'h00 |-> effBlocked == s.heldBeams)
      else $error("blocked beams dropped without smoothing");

   a_bus_answer: assert property (
      (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("bus request not answered in time");

   c_stable_eval: cover property (s.evalPend ##[1:25] divDone);
   c_inverted: cover property (divDone && s.invert);
   c_refused: cover property ($rose(s.reject));
   c_factory: cover property (s.nvSave && s.cfg == bfam_pkg::CFG_DEFAULT);

endmodule
`default_nettype wire

// File: bfam_pkg.sv
// Shared constants and types of the beam filter and analog mapping block.
// Assumes one measurement-cycle clock and a 32-beam receiver.
package bfam_pkg;

   // ----------------------------------------
   // Beam array and converter sizes
   // ----------------------------------------
   localparam int BEAM_COUNT = 32;
   localparam int BEAM_W = 8;
   localparam int DAC_W = 12;
   localparam int DIV_W = 20;
   localparam logic [7:0] BEAM_LAST8 = 8'h20;
   localparam logic [15:0] BEAM_LAST16 = 16'h0020;
   localparam logic [11:0] DAC_MAX = 12'hfff;
   localparam logic [19:0] DIV_LIMIT = 20'h0_0fff;
   localparam logic [4:0] DIV_STEPS = 5'h14;
   localparam logic [15:0] DEPTH_MAX = 16'h00ff;

   // ----------------------------------------
   // Register byte offsets and fields
   // ----------------------------------------
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_DEPTH = 5'h04;
   localparam logic [4:0] REG_SIGNAL = 5'h08;
   localparam logic [4:0] REG_FUNC = 5'h0c;
   localparam logic [4:0] REG_START = 5'h10;
   localparam logic [4:0] REG_END = 5'h14;
   localparam logic [4:0] REG_SMOOTH = 5'h18;
   localparam logic [4:0] REG_STATUS = 5'h1c;
   localparam int CTRL_FACTORY_BIT = 0;
   localparam int ST_REJECT_BIT = 0;
   localparam int ST_INVERT_BIT = 1;
   localparam int ST_STABLE_BIT = 2;
   localparam int ST_LOADED_BIT = 3;
   localparam int ST_VALUE_LSB = 8;
   localparam int ST_CODE_LSB = 16;

   // ----------------------------------------
   // Signal types and evaluation functions
   // ----------------------------------------
   localparam logic [2:0] SIG_OFF = 3'h0;
   localparam logic [2:0] SIG_V0_5 = 3'h1;
   localparam logic [2:0] SIG_V0_10 = 3'h2;
   localparam logic [2:0] SIG_V0_11 = 3'h3;
   localparam logic [2:0] SIG_MA4_20 = 3'h4;
   localparam logic [2:0] SIG_MA0_20 = 3'h5;
   localparam logic [2:0] SIG_MA0_24 = 3'h6;
   localparam logic [2:0] FN_OFF = 3'h0;
   localparam logic [2:0] FN_FIRST_BLOCKED_BEAM = 3'h1;
   localparam logic [2:0] FN_FIRST_CLEAR_BEAM = 3'h2;
   localparam logic [2:0] FN_LAST_BLOCKED_BEAM = 3'h3;
   localparam logic [2:0] FN_LAST_CLEAR_BEAM = 3'h4;
   localparam logic [2:0] FN_TOTAL_BLOCKED_BEAMS = 3'h5;
   localparam logic [2:0] FN_TOTAL_CLEAR_BEAMS = 3'h6;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] depth;
      logic [2:0] sigType;
      logic [2:0] func;
      logic [7:0] startBeam;
      logic [7:0] endBeam;
      logic [7:0] smoothing;
   } bfam_cfg_type;

   typedef struct packed {
      logic enable;
      logic [2:0] range;
      logic [11:0] code;
   } bfam_dac_type;

   localparam bfam_cfg_type CFG_DEFAULT = '{
      depth: 8'h01, sigType: SIG_OFF, func: FN_OFF,
      startBeam: 8'h01, endBeam: 8'h20, smoothing: 8'h00};

endpackage

// File: bfam_divider.sv
// Iterative restoring divider used to scale beam positions onto converter codes.
// Assumes start is a same-clock pulse and that the divisor is never zero.
`timescale 1ns/100ps
`default_nettype none
module bfam_divider (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [19:0] dividend,
   input wire logic [7:0] divisor,
   output logic done,
   output logic [19:0] quotient
);

   typedef struct packed {
      logic busy;
      logic done;
      logic [4:0] cnt;
      logic [7:0] rem;
      logic [19:0] quo;
   } bfam_div_state_type;

   bfam_div_state_type s;
   bfam_div_state_type next_s;
   logic [8:0] trial;

   // One quotient bit per clock; a start while busy is ignored.
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      trial = {s.rem, s.quo[19]};
      if (start && !s.busy) begin
         next_s.busy = 1'b1;
         next_s.cnt = bfam_pkg::DIV_STEPS;
         next_s.rem = 8'h00;
         next_s.quo = dividend;
      end else if (s.busy) begin
         if (trial >= {1'b0, divisor}) begin
            next_s.rem = 8'(trial - {1'b0, divisor});
            next_s.quo = {s.quo[18:0], 1'b1};
         end else begin
            next_s.rem = trial[7:0];
            next_s.quo = {s.quo[18:0], 1'b0};
         end
         next_s.cnt = 5'(s.cnt - 5'h01);
         if (s.cnt == 5'h01) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;
   assign quotient = s.quo;

endmodule
`default_nettype wire

// File: bfam_nv_model.sv
// Non-volatile store model for the beam filter block.
// Assumes the block's mclk, rst_n and load and save ports.
`timescale 1ns/100ps
`default_nettype none
module bfam_nv_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic nvLoadReq,
   output logic nvLoadValid,
   output bfam_pkg::bfam_cfg_type nvLoadImage,
   input wire logic nvSave,
   input wire bfam_pkg::bfam_cfg_type nvImage
);
   bfam_pkg::bfam_cfg_type store = '{8'h02, 3'h0, 3'h0, 8'h01, 8'h20, 8'h00};
   always @(posedge mclk) begin
      nvLoadValid <= rst_n && nvLoadReq && !nvLoadValid;
      if (nvSave) begin
         store <= nvImage;
      end
   end
   // Outside the pulse the image is scrambled, so a stale capture shows up.
   assign nvLoadImage = nvLoadValid ? store : ~store;
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench of the beam filter and analog mapping block.
// Assumes the NV store model and one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, panelWrite = 0, beamStrobe = 0;
   logic nvLoadReq, nvLoadValid, nvSave, avs_waitrequest;
   logic [4:0] avs_address = 0, panelAddr = 0;
   logic [31:0] avs_writedata = 0, panelWriteData = 0, beamBlocked = 0, avs_readdata, q;
   bfam_pkg::bfam_cfg_type nvLoadImage, nvImage;
   bfam_pkg::bfam_dac_type analogOut;
   int n_fail = 0, num_checks = 0, k;
   logic [7:0] s, e;
   logic [2:0] f;
   logic [31:0] b;
   always #5 mclk = ~mclk;
   bfam_top u_bfam_top (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .panelWrite(panelWrite), .panelAddr(panelAddr), .panelWriteData(panelWriteData),
      .beamBlocked(beamBlocked), .beamStrobe(beamStrobe), .nvLoadReq(nvLoadReq),
      .nvLoadValid(nvLoadValid), .nvLoadImage(nvLoadImage), .nvSave(nvSave),
      .nvImage(nvImage), .analogOut(analogOut));
   bfam_nv_model u_bfam_nv_model (.mclk(mclk), .rst_n(rst_n), .nvLoadReq(nvLoadReq),
      .nvLoadValid(nvLoadValid), .nvLoadImage(nvLoadImage), .nvSave(nvSave),
      .nvImage(nvImage));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Each access is held until waitrequest is sampled low at a rising edge.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int i;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (i == 50) begin
         n_fail++;
         finish_test();
      end
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      @(posedge mclk);
   endtask
   task automatic panel(input logic [4:0] a, input logic [31:0] d);
      panelAddr <= a;
      panelWriteData <= d;
      panelWrite <= 1;
      @(posedge mclk);
      panelWrite <= 0;
      @(posedge mclk);
   endtask
   task automatic beam(input logic [31:0] v);
      beamBlocked <= v;
      beamStrobe <= 1;
      @(posedge mclk);
      beamStrobe <= 0;
      repeat (24) @(posedge mclk);
   endtask
   function automatic logic [7:0] ev(input logic [31:0] v, input logic [2:0] fn);
      logic [7:0] r;
      r = 0;
      for (int i = 31; i >= 0; i--) begin
         if ((fn == 1 && v[i]) || (fn == 2 && !v[i])) r = i + 1;
      end
      for (int i = 0; i < 32; i++) begin
         if ((fn == 3 && v[i]) || (fn == 4 && !v[i])) r = i + 1;
         if (fn >= 5 && v[i]) r++;
      end
      if (fn == 6) r = 32 - r;
      return r;
   endfunction
   function automatic logic [31:0] mp(input logic [7:0] v, input logic [7:0] st, input logic [7:0] en);
      int lo, sp, p, c;
      lo = st < en ? st : en;
      sp = (st < en ? en : st) - lo + 1;
      p = v < lo ? 0 : (v >= lo + sp ? sp : v - lo + 1);
      c = p * 4096 / sp;
      if (c > 4095) c = 4095;
      if (en < st) c = 4095 - c;
      return c;
   endfunction
   initial begin
      void'($urandom(33863));
      repeat (16) @(posedge mclk);
      rst_n <= 1;
      repeat (6) @(posedge mclk);
      bus(0, 5'h04, 0);
      chk(q, 2, "boot depth");
      bus(1, 5'h04, 256);
      bus(1, 5'h04, 299);
      bus(0, 5'h04, 0);
      chk(q, 2, "refused depth");
      bus(0, 5'h1c, 0);
      chk(q[0], 1, "reject flag");
      bus(1, 5'h04, 255);
      bus(0, 5'h04, 0);
      chk(q, 255, "max depth");
      $display("test depth done");
      for (k = 0; k < 8; k++) begin
         bus(1, 5'h08, k);
         repeat (2) @(posedge mclk);
         chk(analogOut.range, k < 7 ? k : 6, "range");
         chk(analogOut.enable, k != 0, "enable");
      end
      $display("test signal done");
      bus(1, 5'h08, 1);
      panel(5'h08, 4);
      bus(0, 5'h08, 0);
      chk(q, 4, "panel wins");
      fork
         bus(1, 5'h10, 5);
         begin
            @(posedge mclk);
            panel(5'h10, 9);
         end
      join
      bus(0, 5'h10, 0);
      chk(q, 9, "same cycle panel wins");
      $display("test panel done");
      bus(1, 5'h04, 1);
      for (k = 0; k < 12; k++) begin
         f = k < 6 ? k + 1 : 1 + $urandom % 6;
         s = k == 6 ? 32 : 1 + $urandom % 32;
         e = k == 6 ? 1 : 1 + $urandom % 32;
         b = ($urandom | 32'h0000_0001) & 32'h7fff_ffff;
         bus(1, 5'h0c, f);
         bus(1, 5'h10, s);
         bus(1, 5'h14, e);
         beam(b);
         chk(analogOut.code, mp(ev(b, f), s, e), "code");
      end
      $display("test mapping done");
      bus(1, 5'h0c, 1);
      bus(1, 5'h10, 1);
      bus(1, 5'h14, 32);
      bus(1, 5'h18, 3);
      beam(32'h0000_3c02);
      chk(analogOut.code, mp(8'd11, 8'd1, 8'd32), "smoothed code");
      bus(1, 5'h18, 0);
      beam(32'h0000_0001);
      bus(1, 5'h04, 3);
      beam(32'h0000_0100);
      beam(32'h0000_0100);
      beam(32'h0000_0010);
      beam(32'h0000_0010);
      chk(analogOut.code, 128, "unstable code");
      beam(32'h0000_0010);
      chk(analogOut.code, 640, "stable code");
      $display("test filter done");
      bus(1, 5'h00, 1);
      bus(0, 5'h04, 0);
      chk(q, 1, "factory depth");
      bus(0, 5'h0c, 0);
      chk(q, 0, "factory func");
      chk(u_bfam_nv_model.store[31:0], bfam_pkg::CFG_DEFAULT[31:0], "saved image low");
      chk(32'(u_bfam_nv_model.store[37:32]),
          32'(bfam_pkg::CFG_DEFAULT[37:32]), "saved image high");
      beam(32'h0000_0001);
      chk(analogOut.code, 0, "func off code");
      $display("test factory done");
      finish_test();
   end
endmodule
`default_nettype wire
